//--- bench/scfc_spi_host.sv
// SPI host model that sends 32-bit commands in mode 0.
// Assumes the bench calls xfer and crc4 through the instance.
module scfc_spi_host (
  output logic sclk_o,
  output logic cs_n_o,
  output logic mosi_o,
  input wire logic miso_i
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam realtime HALF = 62.5;

  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    mosi_o = 1'b0;
  end

  // ***************************************************************
  // Seeded x^4+1 check value, message bits then four zeros
  // ***************************************************************
  function automatic logic [3:0] crc4(input logic [3:0] sd,
                                      input logic [31:0] w);
    logic [3:0] r;
    r = sd;
    for (int i = 31; i >= 4; i--) begin
      r = {r[2:0], r[3] ^ w[i]};
    end
    for (int i = 0; i < 4; i++) begin
      r = {r[2:0], r[3]};
    end
    return r;
  endfunction

  // ***************************************************************
  // One frame, MSB first; the clock stands still outside frames
  // ***************************************************************
  task automatic xfer(input logic [31:0] tx, output logic [31:0] rx);
    cs_n_o = 1'b0;
    #(HALF);
    for (int i = 31; i >= 0; i--) begin
      mosi_o = tx[i];
      #(HALF);
      sclk_o = 1'b1;
      rx[i] = miso_i;
      #(HALF);
      sclk_o = 1'b0;
    end
    #(HALF);
    cs_n_o = 1'b1;
    mosi_o = ~tx[0];
    #(4 * HALF);
  endtask

  // ***************************************************************
  // A cut frame of n clocks, to provoke a length error
  // ***************************************************************
  task automatic cut(input int n);
    cs_n_o = 1'b0;
    #(HALF);
    repeat (n) begin
      #(HALF);
      sclk_o = 1'b1;
      #(HALF);
      sclk_o = 1'b0;
    end
    #(HALF);
    cs_n_o = 1'b1;
    #(4 * HALF);
  endtask
endmodule // scfc_spi_host

//--- bench/test_spi_crc4_frame_check.sv
// Self-checking bench for the SPI 4-bit CRC frame checker.
// Assumes the host model and the design files are compiled first.
module test_spi_crc4_frame_check;
  import scfc_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;

  logic clk = 1'b0, rst = 1'b1, we = 1'b0, cyc = 1'b0, stb = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0, dat_o, cmd_o, cap = 32'h0, exp_w, q;
  logic [3:0] sel = 4'h0, seed = 4'ha;
  logic [3:0] rolling_message_counter [8] = '{default: 4'h1};
  logic ack_o, miso_o, miso_oe_o, cmd_valid_o, irq_o, sclk, cs_n, mosi;
  logic rv = 1'b0, re = 1'b0, rh = 1'b0, m4 = 1'b0, have = 1'b0;
  logic [15:0] rd_d = 16'h0;
  logic [1:0] rt = 2'h0;
  int fails = 0, checked = 0, pulses = 0;

  scfc_top i_dut (.clk_i(clk), .rst_i(rst), .adr_i(adr), .dat_i(dat),
    .dat_o(dat_o), .we_i(we), .sel_i(sel), .cyc_i(cyc), .stb_i(stb),
    .ack_o(ack_o), .sclk_i(sclk), .cs_n_i(cs_n), .mosi_i(mosi),
    .miso_o(miso_o), .miso_oe_o(miso_oe_o), .cmd_valid_o(cmd_valid_o),
    .cmd_o(cmd_o), .rsp_valid_i(rv), .rsp_error_i(re),
    .rsp_has_data_i(rh), .rsp_data_i(rd_d), .rsp_detail_i(rt),
    .irq_o(irq_o));
  scfc_spi_host i_host (.sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi),
    .miso_i(miso_o));

  initial begin
    forever #4 clk = ~clk;
  end

  always @(posedge clk) begin
    if (cmd_valid_o === 1'b1) begin
      pulses <= pulses + 1;
      cap <= cmd_o;
    end
  end

  // ***************************************************************
  // Checks, bus cycles and the reference model
  // ***************************************************************
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checked++;
    if (g !== e) begin
      fails++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wb(input logic [7:0] a, input logic w,
                    input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk);
    adr <= a; we <= w; dat <= d; sel <= 4'hf; cyc <= 1'b1; stb <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (ack_o !== 1'b1 && n < 50);
    if (ack_o !== 1'b1) begin
      fails++;
      $display("unexpected bus ack expected 1 seen %b", ack_o);
    end
    r = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input string nm);
    logic [31:0] r;
    wb(a, 1'b0, 32'h0, r);
    chk(nm, e, r);
  endtask

  function automatic logic [31:0] rsp_word(input logic [31:0] c,
    input logic e, input logic h, input logic [15:0] d,
    input logic [1:0] t);
    logic [31:0] w;
    logic [3:0] ec;
    logic [1:0] st;
    ec = {c[28], c[31:29]};
    st = e ? 2'h3 : 2'h0;
    if (!c[28]) w = {e ? 4'h0 : ec, st, 2'h0, d, 8'h00};
    else if (e && !h) w = {4'h0, st, 16'h0, t, 8'h00};
    else begin
      w = {ec, st, d, t, m4 ? rolling_message_counter[c[31:29]] : 4'h0, 4'h0};
      if (m4) rolling_message_counter[c[31:29]] = rolling_message_counter[c[31:29]] + 4'h1;
    end
    if (m4) w[3:0] = i_host.crc4(seed, w);
    return w;
  endfunction

  task automatic frame(input logic [31:0] tx, input logic good);
    logic [31:0] rx;
    int p;
    p = pulses;
    fork
      i_host.xfer(tx, rx);
      begin
        #1003ns;
        chk("miso enable", 32'h1, {31'h0, miso_oe_o});
      end
    join
    if (have) chk("response frame", exp_w, rx);
    repeat (8) @(posedge clk);
    chk("miso enable idle", 32'h0, {31'h0, miso_oe_o});
    chk("command pulses", {31'h0, good}, 32'(pulses - p));
    if (good) chk("command word", tx, cap);
    @(posedge clk);
    rv <= 1'b1; re <= 1'($urandom); rh <= 1'($urandom);
    rd_d <= 16'($urandom); rt <= 2'($urandom);
    repeat (2) @(posedge clk);
    rv <= 1'b0;
    exp_w = good ? rsp_word(tx, re, rh, rd_d, rt)
                 : rsp_word(32'h0, 1'b1, 1'b0, 16'h0, 2'h0);
    have = 1'b1;
  endtask

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  initial begin
    #400us;
    fails++;
    end_sim;
  end

  // ***************************************************************
  // Main sequence
  // ***************************************************************
  initial begin
    logic [31:0] w;
    logic [31:0] tbl [7] = '{32'h8022c10f, 32'h401fc10d, 32'hc0220006,
      32'h601fc10f, 32'h40ff5a01, 32'hc03e000b, 32'h60ff5a03};
    logic [2:0] s;
    logic g;
    void'($urandom(53400));
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    rd(ADDR_CFG, 32'h0, "config reset");
    rd(ADDR_STAT, 32'h0, "status reset");
    rd(ADDR_MASK, 32'h0, "mask reset");
    rd(8'h10, 32'h0, "unmapped read");
    frame(32'h8022c1a5, 1'b1);
    wb(ADDR_CFG, 1'b1, 32'h1a, q);
    rd(ADDR_CFG, 32'h1a, "config write");
    m4 = 1'b1;
    foreach (tbl[i]) frame(tbl[i], 1'b1);
    rd(ADDR_CMD, tbl[6], "last command");
    wb(ADDR_STAT, 1'b0, 32'h0, q);
    frame(tbl[0] ^ 32'h4, 1'b0);
    chk("irq masked", 32'h0, {31'h0, irq_o});
    wb(ADDR_MASK, 1'b1, 32'h1, q);
    repeat (2) @(posedge clk);
    chk("irq raised", 32'h1, {31'h0, irq_o});
    rd(ADDR_STAT, 32'h1, "status crc error");
    repeat (2) @(posedge clk);
    chk("irq cleared", 32'h0, {31'h0, irq_o});
    wb(ADDR_MASK, 1'b1, 32'h0, q);
    i_host.cut(8);
    have = 1'b0;
    rd(ADDR_STAT, 32'h4, "status length error");
    for (int k = 0; k < 40; k++) begin
      s = ($urandom_range(0, 3) == 0) ? 3'($urandom) : 3'h5;
      w = ($urandom_range(0, 3) != 0) ? {s, 1'b1, 28'h0}
          : {s, 1'b0, 4'h0, 16'($urandom), 8'h00};
      w[3:0] = i_host.crc4(seed, w);
      g = ($urandom_range(0, 5) != 0);
      if (!g) w[3:0] = w[3:0] ^ 4'($urandom_range(1, 15));
      frame(w, g);
    end
    end_sim;
  end
endmodule // test_spi_crc4_frame_check

//--- core/scfc_crc4.sv
// Serial-equivalent x^4+1 CRC over one 32-bit word, MSB first.
// Assumes the user drives seed and word from the same clock domain.
module scfc_crc4
  import scfc_pkg::*;
(
  scfc_crc_if.calc crc
);

  // ***************************************************************
  // Shift register unrolled over the word
  // ***************************************************************
  always_comb begin
    logic [3:0] c;
    c = crc.seed;
    for (int i = FRAME_BITS - 1; i >= 0; i--) begin
      c = {c[2:0], c[3] ^ crc.word[i]};
    end
    crc.rem = c;
  end

endmodule // scfc_crc4

//--- core/scfc_crc_if.sv
// Interface carrying one CRC calculation between the core modules.
// Assumes purely combinational use within the system clock domain.
interface scfc_crc_if;
  logic [3:0] seed;
  logic [31:0] word;
  logic [3:0] rem;
  modport calc (input seed, input word, output rem);
  modport user (output seed, output word, input rem);
endinterface

//--- core/scfc_pkg.sv
// Constants and types for the SPI 4-bit CRC frame check block.
// Assumes a 125 MHz system clock and a slow SPI link sampled by it.
package scfc_pkg;

  // ***************************************************************
  // Frame layout
  // ***************************************************************
  localparam int FRAME_BITS = 32;
  localparam int CRC_BITS = 4;
  localparam logic [5:0] FRAME_CNT = 6'h20;
  localparam logic [5:0] CNT_MAX = 6'h3f;
  localparam int CMD_SENS_BIT = 28;
  localparam int SRC_MSB = 31;
  localparam int SRC_LSB = 29;
  localparam logic [1:0] ST_OK = 2'h0;
  localparam logic [1:0] ST_ERR = 2'h3;
  localparam logic [3:0] KAC_INIT = 4'h1;
  localparam logic [3:0] CRC_ZERO = 4'h0;

  // ***************************************************************
  // Registers
  // ***************************************************************
  localparam logic [7:0] ADDR_CFG = 8'h00;
  localparam logic [7:0] ADDR_STAT = 8'h04;
  localparam logic [7:0] ADDR_MASK = 8'h08;
  localparam logic [7:0] ADDR_CMD = 8'h0c;
  localparam int CFG_SEED_LSB = 0;
  localparam int CFG_WID_LSB = 4;
  localparam logic [5:0] CFG_RST = 6'h00;
  localparam logic [1:0] WID_8 = 2'h0;
  localparam logic [1:0] WID_4 = 2'h1;
  localparam logic [1:0] WID_3 = 2'h2;
  localparam int STAT_W = 3;
  localparam int STAT_CRC_ERR = 0;
  localparam int STAT_CMD = 1;
  localparam int STAT_LEN_ERR = 2;

  typedef enum logic [1:0] {
    SCFC_IDLE = 2'b01,
    SCFC_WAIT = 2'b10
  } scfc_state_t;

  // Folds a word into one nibble; equals the x^4+1 remainder.
  function automatic logic [3:0] scfc_fold(input logic [3:0] seed,
                                           input logic [31:0] w);
    logic [3:0] f;
    f = seed;
    for (int i = 0; i < 8; i++) begin
      f = f ^ w[i*4 +: 4];
    end
    return f;
  endfunction

endpackage

//--- core/scfc_top.sv
// SPI frame checker with 4-bit CRC, response builder and counters.
// Assumes SPI mode 0 pins from outside and a classic Wishbone master.
// Contract
// - Register error reply: zero command, status 11, zero 25:24, data, CRC.
// - Data-less sensor error reply: zero command, status 11, detail, CRC.
// - Check CRC over all 32 command bits, MSB first.
// - Drop a command with bad CRC and send the error reply.
// - Preload seed in the checker, then rotate message and CRC in.
// - Command valid only when the final remainder is zero.
// - Both directions use x^4+1 with the configured seed.
// - Response CRC over 32 bits MSB first from seeded register.
// - Four zeros follow the message; result is the CRC field.
// - Sensor replies carry a per-source rolling counter from 0001.
// - CRC width defaults to 8 bits; software may select shorter. Here only the 4-bit setting checks and generates a CRC; other widths use none.
//
// Design decisions made here: the placing of the registers and register access over Wishbone.
module scfc_top
  import scfc_pkg::*;
#(
  parameter int N_SRC = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] adr_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  input wire logic we_i,
  input wire logic [3:0] sel_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  output logic ack_o,
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic mosi_i,
  output logic miso_o,
  output logic miso_oe_o,
  output logic cmd_valid_o,
  output logic [31:0] cmd_o,
  input wire logic rsp_valid_i,
  input wire logic rsp_error_i,
  input wire logic rsp_has_data_i,
  input wire logic [15:0] rsp_data_i,
  input wire logic [1:0] rsp_detail_i,
  output logic irq_o
);

  if (N_SRC != (1 << (SRC_MSB - SRC_LSB + 1))) begin : g_chk
    $error("N_SRC must match the source identifier width.");
  end

  // ***************************************************************
  // Pin synchronisers
  // ***************************************************************
  logic [2:0] sclk_q;
  logic [2:0] cs_q;
  logic [1:0] mosi_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sclk_q <= 3'h0;
      cs_q <= 3'h7;
      mosi_q <= 2'h0;
    end else begin
      sclk_q <= {sclk_q[1:0], sclk_i};
      cs_q <= {cs_q[1:0], cs_n_i};
      mosi_q <= {mosi_q[0], mosi_i};
    end
  end

  logic active;
  logic sclk_rise;
  logic sclk_fall;
  logic cs_fall;
  logic cs_rise;
  assign active = ~cs_q[1];
  assign sclk_rise = sclk_q[1] & ~sclk_q[2];
  assign sclk_fall = ~sclk_q[1] & sclk_q[2];
  assign cs_fall = ~cs_q[1] & cs_q[2];
  assign cs_rise = cs_q[1] & ~cs_q[2];

  // ***************************************************************
  // State
  // ***************************************************************
  scfc_state_t state_r, state_nxt;
  logic [31:0] rx_r, rx_nxt;
  logic [31:0] tx_r, tx_nxt;
  logic [5:0] cnt_r, cnt_nxt;
  logic miso_r, miso_nxt;
  logic oe_r, oe_nxt;
  logic [31:0] cmd_r, cmd_nxt;
  logic cmdv_r, cmdv_nxt;
  logic [3:0] kac_r [N_SRC];
  logic [3:0] kac_nxt [N_SRC];
  logic [5:0] cfg_r, cfg_nxt;
  logic [STAT_W-1:0] stat_r, stat_nxt;
  logic [STAT_W-1:0] mask_r, mask_nxt;
  logic [31:0] dat_r, dat_nxt;
  logic ack_r, ack_nxt;
  logic irq_r, irq_nxt;
  logic cfg_wr_r, cfg_wr_nxt;

  logic [3:0] seed;
  logic wid4;
  logic frame_end;
  logic crc_ok;
  logic build_err;
  logic load;
  logic [SRC_MSB-SRC_LSB:0] src;
  logic [31:0] frame_w;
  logic [3:0] echo;
  logic [3:0] kac_w;
  assign seed = cfg_r[CFG_SEED_LSB +: 4];
  assign wid4 = cfg_r[CFG_WID_LSB +: 2] == WID_4;
  assign src = cmd_r[SRC_MSB:SRC_LSB];
  assign echo = {cmd_r[CMD_SENS_BIT], cmd_r[SRC_MSB:SRC_LSB]};
  assign kac_w = wid4 ? kac_r[src] : CRC_ZERO;

  // ***************************************************************
  // CRC units
  // ***************************************************************
  scfc_crc_if chk_if ();
  scfc_crc_if gen_if ();
  scfc_crc4 u_chk (.crc(chk_if.calc));
  scfc_crc4 u_gen (.crc(gen_if.calc));

  assign chk_if.seed = seed;
  assign chk_if.word = rx_r;
  assign gen_if.seed = seed;
  assign gen_if.word = {frame_w[31:4], CRC_ZERO};

  assign frame_end = cs_rise & (cnt_r == FRAME_CNT);
  assign crc_ok = ~wid4 | (chk_if.rem == CRC_ZERO);
  assign build_err = frame_end & ~crc_ok;
  assign load = (state_r == SCFC_WAIT) & rsp_valid_i & ~active;

  // ***************************************************************
  // Response frame
  // ***************************************************************
  always_comb begin
    if (build_err) begin
      frame_w = {4'h0, ST_ERR, 2'h0, 16'h0, 4'h0, CRC_ZERO};
    end else if (cmd_r[CMD_SENS_BIT]) begin
      if (rsp_error_i & ~rsp_has_data_i) begin
        frame_w = {4'h0, ST_ERR, 2'h0, 14'h0, rsp_detail_i, 4'h0,
                   CRC_ZERO};
      end else begin
        frame_w = {echo, rsp_error_i ? ST_ERR : ST_OK, rsp_data_i,
                   rsp_detail_i, kac_w, CRC_ZERO};
      end
    end else if (rsp_error_i) begin
      frame_w = {4'h0, ST_ERR, 2'h0, rsp_data_i, 4'h0, CRC_ZERO};
    end else begin
      frame_w = {echo, ST_OK, 2'h0, rsp_data_i, 4'h0, CRC_ZERO};
    end
  end

  // ***************************************************************
  // Link and response logic
  // ***************************************************************
  always_comb begin
    state_nxt = state_r;
    rx_nxt = rx_r;
    tx_nxt = tx_r;
    cnt_nxt = cnt_r;
    miso_nxt = miso_r;
    oe_nxt = active;
    cmd_nxt = cmd_r;
    cmdv_nxt = 1'b0;
    kac_nxt = kac_r;
    if (cs_fall) begin
      cnt_nxt = 6'h00;
      miso_nxt = tx_r[31];
      tx_nxt = {tx_r[30:0], 1'b0};
    end else if (active & sclk_rise) begin
      rx_nxt = {rx_r[30:0], mosi_q[1]};
      if (cnt_r != CNT_MAX) begin
        cnt_nxt = cnt_r + 6'h01;
      end
    end else if (active & sclk_fall) begin
      miso_nxt = tx_r[31];
      tx_nxt = {tx_r[30:0], 1'b0};
    end
    if (build_err) begin
      tx_nxt = {frame_w[31:4], wid4 ? gen_if.rem : CRC_ZERO};
      state_nxt = SCFC_IDLE;
    end else if (frame_end) begin
      cmd_nxt = rx_r;
      cmdv_nxt = 1'b1;
      state_nxt = SCFC_WAIT;
    end else if (load) begin
      tx_nxt = {frame_w[31:4], wid4 ? gen_if.rem : CRC_ZERO};
      state_nxt = SCFC_IDLE;
      if (wid4 & cmd_r[CMD_SENS_BIT] & (rsp_has_data_i | ~rsp_error_i)) begin
        kac_nxt[src] = kac_r[src] + 4'h1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= SCFC_IDLE;
      rx_r <= 32'h0;
      tx_r <= 32'h0;
      cnt_r <= 6'h00;
      miso_r <= 1'b0;
      oe_r <= 1'b0;
      cmd_r <= 32'h0;
      cmdv_r <= 1'b0;
      for (int i = 0; i < N_SRC; i++) begin
        kac_r[i] <= KAC_INIT;
      end
    end else begin
      state_r <= state_nxt;
      rx_r <= rx_nxt;
      tx_r <= tx_nxt;
      cnt_r <= cnt_nxt;
      miso_r <= miso_nxt;
      oe_r <= oe_nxt;
      cmd_r <= cmd_nxt;
      cmdv_r <= cmdv_nxt;
      kac_r <= kac_nxt;
    end
  end

  // ***************************************************************
  // Wishbone registers and interrupt
  // ***************************************************************
  always_comb begin
    logic req;
    logic [STAT_W-1:0] set;
    logic [STAT_W-1:0] clr;
    req = cyc_i & stb_i & ~ack_r;
    set = '0;
    clr = '0;
    cfg_nxt = cfg_r;
    mask_nxt = mask_r;
    dat_nxt = dat_r;
    cfg_wr_nxt = cfg_wr_r;
    ack_nxt = req;
    set[STAT_CRC_ERR] = build_err;
    set[STAT_CMD] = frame_end & crc_ok;
    set[STAT_LEN_ERR] = cs_rise & (cnt_r != FRAME_CNT);
    if (req & we_i & sel_i[0]) begin
      if (adr_i == ADDR_CFG) begin
        cfg_nxt = dat_i[5:0];
        cfg_wr_nxt = 1'b1;
      end else if (adr_i == ADDR_MASK) begin
        mask_nxt = dat_i[STAT_W-1:0];
      end
    end
    if (req & ~we_i) begin
      if (adr_i == ADDR_CFG) begin
        dat_nxt = {26'h0, cfg_r};
      end else if (adr_i == ADDR_STAT) begin
        dat_nxt = {{(32-STAT_W){1'b0}}, stat_r};
        clr = '1;
      end else if (adr_i == ADDR_MASK) begin
        dat_nxt = {{(32-STAT_W){1'b0}}, mask_r};
      end else if (adr_i == ADDR_CMD) begin
        dat_nxt = cmd_r;
      end else begin
        dat_nxt = 32'h0;
      end
    end
    stat_nxt = (stat_r & ~clr) | set;
    irq_nxt = |(stat_r & mask_r);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_r <= CFG_RST;
      mask_r <= '0;
      stat_r <= '0;
      dat_r <= 32'h0;
      ack_r <= 1'b0;
      irq_r <= 1'b0;
      cfg_wr_r <= 1'b0;
    end else begin
      cfg_r <= cfg_nxt;
      mask_r <= mask_nxt;
      stat_r <= stat_nxt;
      dat_r <= dat_nxt;
      ack_r <= ack_nxt;
      irq_r <= irq_nxt;
      cfg_wr_r <= cfg_wr_nxt;
    end
  end

  assign dat_o = dat_r;
  assign ack_o = ack_r;
  assign irq_o = irq_r;
  assign miso_o = miso_r;
  assign miso_oe_o = oe_r;
  assign cmd_valid_o = cmdv_r;
  assign cmd_o = cmd_r;

  // ***************************************************************
  // Assertions
  // ***************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  chk_fold_a: assert property (
    chk_if.rem == scfc_fold(seed, rx_r))
    else $error("Command remainder is not the seeded x^4+1 remainder.");

  bad_crc_drop_a: assert property (
    frame_end & wid4 & (chk_if.rem != CRC_ZERO)
    |=> !cmdv_r && stat_r[STAT_CRC_ERR] && tx_r[27:26] == ST_ERR)
    else $error("Corrupted command was not dropped.");

  good_crc_take_a: assert property (
    frame_end & wid4 & (chk_if.rem == CRC_ZERO)
    |=> cmdv_r && cmd_o == $past(rx_r) ##1 !cmdv_r)
    else $error("Valid command was not passed on for one cycle.");

  reg_err_frame_a: assert property (
    load & ~cmd_r[CMD_SENS_BIT] & rsp_error_i
    |=> tx_r[31:24] == 8'h0c && tx_r[7:4] == 4'h0
        && tx_r[23:8] == $past(rsp_data_i))
    else $error("Register error reply is malformed.");

  sens_err_nodata_a: assert property (
    load & cmd_r[CMD_SENS_BIT] & rsp_error_i & ~rsp_has_data_i
    |=> tx_r[31:26] == 6'h03 && tx_r[23:10] == 14'h0
        && tx_r[9:8] == $past(rsp_detail_i) && tx_r[7:4] == 4'h0)
    else $error("Sensor error reply without data is malformed.");

  resp_crc_a: assert property (
    (load | build_err) & wid4
    |=> scfc_fold(seed, {tx_r[31:4], CRC_ZERO}) == tx_r[3:0])
    else $error("Response CRC field is wrong.");

  kac_roll_a: assert property (
    load & wid4 & cmd_r[CMD_SENS_BIT] & ~rsp_error_i
    |=> tx_r[7:4] == $past(kac_r[src])
        && kac_r[$past(src)] == $past(kac_r[src]) + 4'h1)
    else $error("Rolling counter not sent or not advanced.");

  sens_err_data_a: assert property (
    load & cmd_r[CMD_SENS_BIT] & rsp_error_i & rsp_has_data_i
    |=> tx_r[31:28] == $past(echo) && tx_r[27:26] == ST_ERR
        && tx_r[25:10] == $past(rsp_data_i))
    else $error("Sensor error reply with data is malformed.");

  wid_default_a: assert property (
    !cfg_wr_r |-> cfg_r[CFG_WID_LSB +: 2] == WID_8)
    else $error("CRC width left its default without a write.");

  crc_err_c: cover property (build_err);
  sens_rsp_c: cover property (load & cmd_r[CMD_SENS_BIT] & wid4);
  reg_rsp_c: cover property (load & ~cmd_r[CMD_SENS_BIT]);
  irq_c: cover property ($rose(irq_r));

endmodule // scfc_top
